// *** dv/tar_link_chk.sv ***
// Checker of the byte link between host controller and alarm registers
`timescale 1ns/1ps
`default_nettype none
`include "tar_defs.svh"
module tar_link_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic start,
    input wire logic write,
    input wire logic [1:0] ptr,
    input wire logic strb,
    input wire logic [7:0] wbyte,
    input wire logic stop,
    input wire logic rvalid,
    input wire logic [7:0] rbyte
);
    logic [1:0] slot_reg;

    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Byte slots since start, saturating
    always_ff @(posedge CLK) begin
        if (!RST_N || start) begin
            slot_reg <= 2'd0;
        end else if (strb && slot_reg != 2'd3) begin
            slot_reg <= slot_reg + 2'd1;
        end
    end

    AST_RVALID_STRB: assert property (strb && !write |=> rvalid)
        else $error("read slot without byte answer");
    AST_RVALID_CAUSE: assert property (rvalid |-> $past(strb) && !$past(write))
        else $error("byte answer without read slot");
    AST_RBYTE_HOLD: assert property ($changed(rbyte) |-> rvalid)
        else $error("read byte changed outside an answer");
    AST_WBYTE_HOLD: assert property ($changed(wbyte) |-> strb)
        else $error("write byte changed outside a byte slot");
    AST_READING_PAD: assert property (
        rvalid && ptr == `TAR_PTR_READING && slot_reg == 2'd2 |-> rbyte[4:0] == 5'h00)
        else $error("reading lower byte padding not zero");
    AST_LIMIT_PAD: assert property (
        rvalid && ptr[1] && slot_reg == 2'd2 |-> rbyte[6:0] == 7'h00)
        else $error("limit lower byte padding not zero");
    AST_SETUP_LOW: assert property (
        rvalid && ptr == `TAR_PTR_SETUP && slot_reg == 2'd2 |-> rbyte == 8'h00)
        else $error("setup second byte not zero");
    AST_START_STRB: assert property (start |=> strb && !stop)
        else $error("start not followed by a byte slot");
    AST_UPPER_NEXT: assert property (rvalid && slot_reg == 2'd1 |-> ##[1:4] (strb || stop))
        else $error("upper byte left without follow-up");
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for host controller and alarm registers joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "tar_defs.svh"
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic conv_done = 1'b0;
    logic [10:0] conv_value = 11'h000;
    logic alert_out;
    logic convert_en;
    logic [7:0] setup_view;
    int num_errors = 0;
    int comparisons = 0;
    integer seed = 52;
    logic [31:0] rd;
    logic [15:0] q;
    logic [15:0] w;
    logic [10:0] v;
    logic [7:0] b;
    logic [1:0] p;

    always #4 clk = ~clk;

    tar_link_if tar_link_if_i();
    tar_host tar_host_i(.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .LINK(tar_link_if_i));
    tar_device tar_device_i(.CLK(clk), .RST_N(rst_n), .LINK(tar_link_if_i),
        .CONV_DONE(conv_done), .CONV_VALUE(conv_value), .ALERT_OUT(alert_out),
        .CONVERT_EN(convert_en), .SETUP_VIEW(setup_view));
    tar_link_chk tar_link_chk_i(.CLK(clk), .RST_N(rst_n), .start(tar_link_if_i.start),
        .write(tar_link_if_i.write), .ptr(tar_link_if_i.ptr), .strb(tar_link_if_i.strb),
        .wbyte(tar_link_if_i.wbyte), .stop(tar_link_if_i.stop),
        .rvalid(tar_link_if_i.rvalid), .rbyte(tar_link_if_i.rbyte));

    function automatic int qlen(input logic [1:0] c);
        return (c == 2'd0) ? 1 : (c == 2'd1) ? 2 : (c == 2'd2) ? 4 : 6;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic alert_is(input logic act, input logic pol);
        chk({31'h0, alert_out}, {31'h0, pol ? act : ~act});
    endtask

    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 100) begin
            num_errors++;
            $display("ERROR %0t: bus wait limit", $time);
        end
    endtask

    task automatic link(input logic [1:0] pt, input logic wr, input logic two,
                        input logic [15:0] wd, output logic [15:0] r);
        logic [31:0] s;
        int n;
        av(1'b1, `TAR_HOST_DATA, {16'h0000, wd}, s);
        av(1'b1, `TAR_HOST_CMD, {28'h000_0000, two, wr, pt}, s);
        repeat (3) @(posedge clk);
        n = 0;
        do begin
            av(1'b0, `TAR_HOST_STATUS, 32'h0000_0000, s);
            n++;
        end while (s[0] !== 1'b0 && n < 50);
        if (s[0] !== 1'b0) begin
            num_errors++;
            $display("ERROR %0t: link busy limit", $time);
        end
        av(1'b0, `TAR_HOST_RDATA, 32'h0000_0000, s);
        r = s[15:0];
    endtask

    task automatic setup(input logic [7:0] sb);
        link(`TAR_PTR_SETUP, 1'b1, 1'b0, {sb, 8'h00}, q);
    endtask

    task automatic conv(input logic [10:0] val);
        @(posedge clk);
        conv_value <= val;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("ERROR %0t: run limit reached", $time);
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({24'h00_0000, setup_view}, 32'h0000_0000);
        chk({30'h0, alert_out, convert_en}, 32'h0000_0003);
        av(1'b0, 4'h1, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        link(`TAR_PTR_OVER, 1'b0, 1'b1, 16'h0000, q);
        chk({16'h0000, q}, {16'h0000, `TAR_OVER_RST, `TAR_LIMIT_PAD});
        link(`TAR_PTR_RELEASE, 1'b0, 1'b1, 16'h0000, q);
        chk({16'h0000, q}, {16'h0000, `TAR_RELEASE_RST, `TAR_LIMIT_PAD});
        // Readings, corner values first
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 11'h3F8 : (i == 1) ? 11'h400 : (i == 2) ? 11'h7FF : 11'($random(seed));
            conv(v);
            link(`TAR_PTR_READING, 1'b0, 1'b1, 16'h0000, q);
            chk({16'h0000, q}, {16'h0000, v, 5'h00});
            link(`TAR_PTR_READING, 1'b0, 1'b0, 16'h0000, q);
            chk({24'h00_0000, q[15:8]}, {24'h00_0000, v[10:3]});
        end
        link(`TAR_PTR_READING, 1'b1, 1'b1, 16'hFFFF, q);
        setup(8'h01);
        chk({31'h0, convert_en}, 32'h0000_0000);
        conv(11'h155);
        link(`TAR_PTR_READING, 1'b0, 1'b1, 16'h0000, q);
        chk({16'h0000, q}, {16'h0000, v, 5'h00});
        // Setup byte, reserved bits first
        for (int i = 0; i < 8; i++) begin
            b = (i == 0) ? 8'hE0 : 8'($random(seed));
            setup(b);
            link(`TAR_PTR_SETUP, 1'b0, 1'b1, 16'h0000, q);
            chk({16'h0000, q}, {16'h0000, b, 8'h00});
            chk({24'h00_0000, setup_view}, {24'h00_0000, b});
        end
        // Limits; a one-byte write is dropped
        for (int i = 0; i < 6; i++) begin
            p = i[0] ? `TAR_PTR_OVER : `TAR_PTR_RELEASE;
            w = 16'($random(seed));
            link(p, 1'b1, 1'b1, w, q);
            link(p, 1'b1, 1'b0, ~w, q);
            link(p, 1'b0, 1'b1, 16'h0000, q);
            chk({16'h0000, q}, {16'h0000, w[15:7], 7'h00});
        end
        // Comparator behaviour for every queue code
        setup(8'h00);
        link(`TAR_PTR_OVER, 1'b1, 1'b1, {9'd20, 7'h00}, q);
        link(`TAR_PTR_RELEASE, 1'b1, 1'b1, {9'd10, 7'h00}, q);
        conv(11'h000);
        for (int c = 0; c < 4; c++) begin
            setup({3'b000, 2'(c), 3'b000});
            conv({9'd20, 2'b11});
            alert_is(1'b0, 1'b0);
            for (int k = 1; k <= qlen(2'(c)); k++) begin
                conv({9'd30, 2'b00});
                alert_is(k == qlen(2'(c)), 1'b0);
            end
            link(`TAR_PTR_SETUP, 1'b0, 1'b0, 16'h0000, q);
            alert_is(1'b1, 1'b0);
            for (int k = 1; k <= qlen(2'(c)); k++) begin
                conv({9'd5, 2'b00});
                alert_is(k < qlen(2'(c)), 1'b0);
            end
        end
        setup(8'h04);
        alert_is(1'b0, 1'b1);
        // Interrupt behaviour
        setup(8'h02);
        conv({9'd30, 2'b00});
        alert_is(1'b1, 1'b0);
        conv({9'd5, 2'b00});
        alert_is(1'b1, 1'b0);
        link(`TAR_PTR_READING, 1'b0, 1'b0, 16'h0000, q);
        alert_is(1'b0, 1'b0);
        conv({9'd30, 2'b00});
        alert_is(1'b0, 1'b0);
        conv({9'd5, 2'b00});
        alert_is(1'b1, 1'b0);
        link(`TAR_PTR_OVER, 1'b0, 1'b1, 16'h0000, q);
        alert_is(1'b0, 1'b0);
        // Shutdown clears a pending interrupt; a clean conversion breaks a fault run
        conv({9'd30, 2'b00});
        alert_is(1'b1, 1'b0);
        setup(8'h03);
        alert_is(1'b0, 1'b0);
        setup(8'h08);
        conv({9'd30, 2'b00});
        conv({9'd15, 2'b00});
        conv({9'd30, 2'b00});
        alert_is(1'b0, 1'b0);
        conv({9'd30, 2'b00});
        alert_is(1'b1, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire

// *** verilog/tar_alarm.sv ***
// Limit comparison, fault queue and alert state
`timescale 1ns/1ps
`default_nettype none
`include "tar_defs.svh"
module tar_alarm
    import tar_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic conv_done,
    input wire logic [10:0] reading,
    input wire logic [8:0] over_limit,
    input wire logic [8:0] release_limit,
    input wire logic [1:0] trip_count_select,
    input wire logic alert_mode_select,
    input wire logic shutdown,
    input wire logic read_clear,
    output logic alert_active
);
    logic alert_reg;
    logic expect_low_reg;
    logic [2:0] count_reg;
    logic [8:0] top9;
    logic above;
    logic below;
    logic look_low;
    logic fault;
    logic eval;
    logic [2:0] count_next;
    logic hit;

    assign top9 = reading[10:2];
    assign above = $signed(top9) > $signed(over_limit);
    assign below = $signed(top9) < $signed(release_limit);
    // Direction of the next trip
    assign look_low = alert_mode_select ? expect_low_reg : alert_reg;
    assign fault = look_low ? below : above;
    // No evaluation while stopped or while an interrupt is pending
    assign eval = conv_done && !shutdown && !(alert_mode_select && alert_reg);
    assign count_next = count_reg + 3'h1;
    assign hit = fault && (count_next >= tar_trip_count(trip_count_select));
    assign alert_active = alert_reg;

    // Consecutive fault counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= 3'h0;
        end else if (eval) begin
            count_reg <= (hit || !fault) ? 3'h0 : count_next;
        end
    end

    // Alert state; a trip wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alert_reg <= 1'b0;
        end else if (eval && hit) begin
            alert_reg <= alert_mode_select ? 1'b1 : !alert_reg;
        end else if (alert_mode_select && (read_clear || shutdown)) begin
            alert_reg <= 1'b0;
        end
    end

    // Alternating trip direction in interrupt behaviour
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            expect_low_reg <= 1'b0;
        end else if (eval && hit && alert_mode_select) begin
            expect_low_reg <= !expect_low_reg;
        end
    end
endmodule
`default_nettype wire

// *** verilog/tar_defs.svh ***
// Constants for the thermal alarm registers and their link
`ifndef TAR_DEFS_SVH
`define TAR_DEFS_SVH
// Pointer codes on the link
`define TAR_PTR_READING 2'h0
`define TAR_PTR_SETUP 2'h1
`define TAR_PTR_RELEASE 2'h2
`define TAR_PTR_OVER 2'h3
// Setup byte fields
`define TAR_SETUP_RSVD_MSB 7
`define TAR_SETUP_RSVD_LSB 5
`define TAR_SETUP_TRIP_MSB 4
`define TAR_SETUP_TRIP_LSB 3
`define TAR_SETUP_POL_BIT 2
`define TAR_SETUP_MODE_BIT 1
`define TAR_SETUP_SHDN_BIT 0
// Reset values
`define TAR_SETUP_RST 8'h00
`define TAR_OVER_RST 9'h0A0
`define TAR_RELEASE_RST 9'h096
`define TAR_READING_RST 11'h000
// Padding below the data in the lower byte
`define TAR_READING_PAD 5'h00
`define TAR_LIMIT_PAD 7'h00
// Host register byte offsets
`define TAR_HOST_CMD 4'h0
`define TAR_HOST_DATA 4'h4
`define TAR_HOST_STATUS 4'h8
`define TAR_HOST_RDATA 4'hC
// Host command fields
`define TAR_CMD_WRITE_BIT 2
`define TAR_CMD_TWO_BIT 3
`endif

// *** verilog/tar_device.sv ***
// Thermal alarm register bank, device end of the link
// Contract
// - Setup byte is writable and reads back
// - Setup bits 7-5 reserved, default zero
// - Bits 4-3 pick 1, 2, 4 or 6 faults
// - Bit 2 sets alert active level
// - Bit 1 picks comparator or interrupt behaviour
// - Bit 0 set stops conversions
// - Reading is read-only, upper byte first
// - Reading is 11-bit, 0.125 degree steps
// - Reading lower byte bits 4-0 are zero
// - Each conversion loads the reading
// - Host collects all sixteen reading bits
// - One-byte reading read gives upper byte
// - Limits are 9-bit, writable and readable
// - Limit lower byte bits 6-0 read zero
// - Host collects all sixteen limit bits
// - Each conversion compares against both limits; code uses one limit per trip direction, none while an interrupt is pending
// - Comparison uses top nine reading bits
// - Comparator: set above over, clear below release
// - Interrupt: held until read, directions alternate
// - Trip needs selected run of faulty conversions
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tar_defs.svh"
module tar_device
    import tar_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    tar_link_if.device LINK,
    input wire logic CONV_DONE,
    input wire logic [10:0] CONV_VALUE,
    output logic ALERT_OUT,
    output logic CONVERT_EN,
    output logic [7:0] SETUP_VIEW
);
    logic [7:0] setup_reg;
    logic [8:0] over_reg;
    logic [8:0] release_reg;
    logic [10:0] reading_reg;
    logic [1:0] ptr_reg;
    logic write_reg;
    logic [1:0] cnt_reg;
    logic [15:0] buf_reg;
    logic [15:0] snap_reg;
    logic rvalid_reg;
    logic [7:0] rbyte_reg;
    logic alert_out_reg;
    logic convert_en_reg;
    logic alert_active;
    logic shutdown;
    logic conv_take;
    logic read_clear;
    logic commit;

    // Sixteen-bit image of a register as the link shows it
    function automatic logic [15:0] reg_image(input logic [1:0] ptr);
        unique case (ptr)
            `TAR_PTR_READING: reg_image = {reading_reg, `TAR_READING_PAD};
            `TAR_PTR_SETUP: reg_image = {setup_reg, 8'h00};
            `TAR_PTR_RELEASE: reg_image = {release_reg, `TAR_LIMIT_PAD};
            `TAR_PTR_OVER: reg_image = {over_reg, `TAR_LIMIT_PAD};
        endcase
    endfunction

    // Byte of the snapshot for a byte position
    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic [1:0] idx);
        unique case (idx)
            2'h0: pick_byte = word[15:8];
            2'h1: pick_byte = word[7:0];
            default: pick_byte = 8'h00;
        endcase
    endfunction

    assign shutdown = setup_reg[`TAR_SETUP_SHDN_BIT];
    assign conv_take = CONV_DONE && !shutdown;
    assign read_clear = LINK.stop && !write_reg && (cnt_reg != 2'h0);
    assign commit = LINK.stop && write_reg;

    assign LINK.rvalid = rvalid_reg;
    assign LINK.rbyte = rbyte_reg;
    assign ALERT_OUT = alert_out_reg;
    assign CONVERT_EN = convert_en_reg;
    assign SETUP_VIEW = setup_reg;

    tar_alarm u_alarm (
        .clk(CLK),
        .rst_n(RST_N),
        .conv_done(conv_take),
        .reading(CONV_VALUE),
        .over_limit(over_reg),
        .release_limit(release_reg),
        .trip_count_select(setup_reg[`TAR_SETUP_TRIP_MSB:`TAR_SETUP_TRIP_LSB]),
        .alert_mode_select(setup_reg[`TAR_SETUP_MODE_BIT]),
        .shutdown(shutdown),
        .read_clear(read_clear),
        .alert_active(alert_active)
    );

    // Transaction header: pointer and direction
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ptr_reg <= `TAR_PTR_READING;
            write_reg <= 1'b0;
        end else if (LINK.start) begin
            ptr_reg <= LINK.ptr;
            write_reg <= LINK.write;
        end
    end

    // Byte position within the transaction, saturating at two
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_reg <= 2'h0;
        end else if (LINK.start) begin
            cnt_reg <= 2'h0;
        end else if (LINK.strb && cnt_reg != 2'h2) begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end

    // Write bytes collect upper first
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            buf_reg <= 16'h0000;
        end else if (LINK.strb && write_reg) begin
            if (cnt_reg == 2'h0) begin
                buf_reg[15:8] <= LINK.wbyte;
            end else if (cnt_reg == 2'h1) begin
                buf_reg[7:0] <= LINK.wbyte;
            end
        end
    end

    // Word snapshot keeps both read bytes from one value
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            snap_reg <= 16'h0000;
        end else if (LINK.start) begin
            snap_reg <= reg_image(LINK.ptr);
        end
    end

    // Read bytes, upper byte first, one cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rvalid_reg <= 1'b0;
            rbyte_reg <= 8'h00;
        end else begin
            rvalid_reg <= LINK.strb && !write_reg;
            if (LINK.strb && !write_reg) begin
                rbyte_reg <= pick_byte(snap_reg, cnt_reg);
            end
        end
    end

    // Setup byte, all eight bits stored as written
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            setup_reg <= `TAR_SETUP_RST;
        end else if (commit && ptr_reg == `TAR_PTR_SETUP && cnt_reg != 2'h0) begin
            setup_reg <= buf_reg[15:8];
        end
    end

    // Over limit, only a full two-byte write commits
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            over_reg <= `TAR_OVER_RST;
        end else if (commit && ptr_reg == `TAR_PTR_OVER && cnt_reg == 2'h2) begin
            over_reg <= buf_reg[15:7];
        end
    end

    // Release limit, only a full two-byte write commits
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            release_reg <= `TAR_RELEASE_RST;
        end else if (commit && ptr_reg == `TAR_PTR_RELEASE && cnt_reg == 2'h2) begin
            release_reg <= buf_reg[15:7];
        end
    end

    // Reading word, writes to it are ignored
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            reading_reg <= `TAR_READING_RST;
        end else if (conv_take) begin
            reading_reg <= CONV_VALUE;
        end
    end

    // Alert level with polarity applied
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            alert_out_reg <= 1'b1;
        end else begin
            alert_out_reg <= alert_active ^ !setup_reg[`TAR_SETUP_POL_BIT];
        end
    end

    // Conversion request to the converter
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            convert_en_reg <= 1'b1;
        end else begin
            convert_en_reg <= !shutdown;
        end
    end
endmodule
`default_nettype wire

// *** verilog/tar_host.sv ***
// Host controller: Avalon-MM registers driving the byte link
`timescale 1ns/1ps
`default_nettype none
`include "tar_defs.svh"
module tar_host
    import tar_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    tar_link_if.host LINK
);
    tar_host_state_t state_reg;
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic two_reg;
    logic idx_reg;
    logic start_reg;
    logic write_reg;
    logic [1:0] ptr_reg;
    logic strb_reg;
    logic [7:0] wbyte_reg;
    logic stop_reg;
    logic take_wr;
    logic cmd_go;
    logic byte_done;
    logic last;

    assign take_wr = AVS_WRITE && !wait_reg;
    assign cmd_go = take_wr && AVS_ADDRESS == `TAR_HOST_CMD && state_reg == TAR_IDLE;
    assign byte_done = write_reg || LINK.rvalid;
    assign last = (idx_reg == two_reg);
    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA = readdata_reg;
    assign LINK.start = start_reg;
    assign LINK.write = write_reg;
    assign LINK.ptr = ptr_reg;
    assign LINK.strb = strb_reg;
    assign LINK.wbyte = wbyte_reg;
    assign LINK.stop = stop_reg;

    // One wait cycle, then the access is taken
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !((AVS_READ || AVS_WRITE) && wait_reg);
            unique case (AVS_ADDRESS)
                `TAR_HOST_DATA: readdata_reg <= {16'h0000, wdata_reg};
                `TAR_HOST_STATUS: readdata_reg <= {31'h0000_0000, state_reg != TAR_IDLE};
                `TAR_HOST_RDATA: readdata_reg <= {16'h0000, rdata_reg};
                default: readdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Write data register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wdata_reg <= 16'h0000;
        end else if (take_wr && AVS_ADDRESS == `TAR_HOST_DATA) begin
            wdata_reg <= AVS_WRITEDATA[15:0];
        end
    end

    // Read data: a one-byte read leaves the lower byte zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_reg <= 16'h0000;
        end else if (cmd_go && !AVS_WRITEDATA[`TAR_CMD_WRITE_BIT]) begin
            rdata_reg <= 16'h0000;
        end else if (state_reg == TAR_WAIT && !write_reg && LINK.rvalid) begin
            if (!idx_reg) begin
                rdata_reg[15:8] <= LINK.rbyte;
            end else begin
                rdata_reg[7:0] <= LINK.rbyte;
            end
        end
    end

    // Link sequencer: start, bytes, stop
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= TAR_IDLE;
            start_reg <= 1'b0;
            write_reg <= 1'b0;
            ptr_reg <= `TAR_PTR_READING;
            two_reg <= 1'b0;
            idx_reg <= 1'b0;
            strb_reg <= 1'b0;
            wbyte_reg <= 8'h00;
            stop_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                TAR_IDLE: begin
                    stop_reg <= 1'b0;
                    if (cmd_go) begin
                        start_reg <= 1'b1;
                        ptr_reg <= AVS_WRITEDATA[1:0];
                        write_reg <= AVS_WRITEDATA[`TAR_CMD_WRITE_BIT];
                        two_reg <= AVS_WRITEDATA[`TAR_CMD_TWO_BIT];
                        idx_reg <= 1'b0;
                        state_reg <= TAR_XFER;
                    end
                end
                TAR_XFER: begin
                    start_reg <= 1'b0;
                    strb_reg <= 1'b1;
                    wbyte_reg <= idx_reg ? wdata_reg[7:0] : wdata_reg[15:8];
                    state_reg <= TAR_WAIT;
                end
                TAR_WAIT: begin
                    strb_reg <= 1'b0;
                    if (byte_done && last) begin
                        stop_reg <= 1'b1;
                        state_reg <= TAR_STOP;
                    end else if (byte_done) begin
                        idx_reg <= 1'b1;
                        state_reg <= TAR_XFER;
                    end
                end
                TAR_STOP: begin
                    stop_reg <= 1'b0;
                    state_reg <= TAR_IDLE;
                end
                default: state_reg <= TAR_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verilog/tar_link_if.sv ***
// Byte link between the host controller and the alarm registers
`timescale 1ns/1ps
`default_nettype none
interface tar_link_if;
    logic start;
    logic write;
    logic [1:0] ptr;
    logic strb;
    logic [7:0] wbyte;
    logic stop;
    logic rvalid;
    logic [7:0] rbyte;

    modport device(input start, input write, input ptr, input strb, input wbyte,
                   input stop, output rvalid, output rbyte);
    modport host(output start, output write, output ptr, output strb, output wbyte,
                 output stop, input rvalid, input rbyte);
endinterface
`default_nettype wire

// *** verilog/tar_pkg.sv ***
// Types and helpers shared by both ends of the thermal alarm link
`default_nettype none
package tar_pkg;
    typedef enum logic [2:0] {
        TAR_IDLE = 3'b000,
        TAR_XFER = 3'b001,
        TAR_WAIT = 3'b010,
        TAR_STOP = 3'b011
    } tar_host_state_t;

    // Trip count for a fault queue code
    function automatic logic [2:0] tar_trip_count(input logic [1:0] sel);
        unique case (sel)
            2'b00: tar_trip_count = 3'h1;
            2'b01: tar_trip_count = 3'h2;
            2'b10: tar_trip_count = 3'h4;
            2'b11: tar_trip_count = 3'h6;
        endcase
    endfunction
endpackage
`default_nettype wire
